//--- rtl/tws_cfg.svh
// tws_cfg.svh: register offsets, field positions, reset values and counts for the two-wire port.
// assumes it is included by bare name from every file that needs these figures.
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH

// special-function-register offsets
`define TWS_ADR_CTRL  8'hE8
`define TWS_ADR_DATA  8'h9A
`define TWS_ADR_OWN   8'h9B
`define TWS_ADR_IEP   8'hA9
`define TWS_ADR_IP    8'hB8

// serial_control_reg field positions
`define TWS_B_DOUT    7
`define TWS_B_DDRV    6
`define TWS_B_COUT    5
`define TWS_B_DIN     4
`define TWS_B_MSEL    3
`define TWS_B_SRST    2
`define TWS_B_DIR     1
`define TWS_B_DONE    0

// serial_irq_enable_priority field positions
`define TWS_B_IEN     0
`define TWS_B_IPRI    4

// reset values
`define TWS_RST_CTRL  8'h00
`define TWS_RST_BYTE  8'h00

// address and bit counting
`define TWS_GENCALL   7'h00
`define TWS_FULL      4'h8
`define TWS_LAST      4'h7
`define TWS_CNT0      4'h0
`define TWS_CNT1      4'h1

`endif

//--- rtl/tws_pkg.sv
// tws_pkg: types shared by the two-wire port files.
// assumes tws_cfg.svh carries the numeric figures.
package tws_pkg;

  typedef logic [7:0] tws_byte_t;

  // slave sequencer states, one-hot
  typedef enum logic [6:0] {
    TWS_IDLE = 7'h01,
    TWS_ADDR = 7'h02,
    TWS_ACKA = 7'h04,
    TWS_RX   = 7'h08,
    TWS_ACKR = 7'h10,
    TWS_TX   = 7'h20,
    TWS_ACKT = 7'h40
  } tws_state_e;

endpackage

//--- rtl/tws_sync.sv
// tws_sync: two-flop synchroniser for one pin level.
// assumes the pin idles high, as a pulled-up bus line does.
`timescale 1ns/1ps
`default_nettype none

module tws_sync (
  input  wire logic clk_i,  // core clock
  input  wire logic rst_i,  // async reset, active high
  input  wire logic d_i,    // asynchronous pin level
  output logic      q_o     // synchronised level
);

  logic meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= 1'b1;
      q_o     <= 1'b1;
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end

endmodule

`default_nettype wire

//--- rtl/tws_top.sv
// tws_top: two-wire serial port with a hardware slave and a bit-bang master mode.
// assumes an 8-bit special-function-register port on clk_i; bus lines are sampled via
// two flops, and the pad logic resolves level from the output enables.
`timescale 1ns/1ps
`default_nettype none
`include "tws_cfg.svh"

// How it works
// - a stop on the bus sends the slave back to idle.
// - a not-acknowledge after a sent byte sends the slave back to idle.
// - the soft reset bit holds the slave in idle, dropping any transfer.
// - the all-zero general call address is never acknowledged.
// - a repeated start restarts address reception like a fresh start.
// - direction bit reloads on every matching address; no separate restart flag.
// - no start-byte handling in slave mode; firmware may send it as master.
// - only seven-bit addresses; ten-bit sequences are not recognised.
// - after an address or data byte the clock is held low until flag clears.
// - master mode gives no readback of the clock line level.
// - master mode does not sample data while driving it; no arbitration.
// - any read or write of the data register clears the byte flag.
// - weak pull-ups on while two-wire mode, off in the other serial mode.
// - interrupt enable is bit 0, priority bit 4, of the register at A9h.
// - address sits in the upper seven bits, direction in the lowest bit.
// - a transaction may end with a repeated start instead of a stop.
// - master mode needs no interrupt or own address; no byte events occur.
// - flag sets after address match and after acked bytes, not after nack.
// - direction bit takes the read/write bit: set for read, clear for write.
module tws_top (
  input  wire logic           clk_i,        // core clock, 50 MHz
  input  wire logic           rst_i,        // async reset, active high
  input  wire logic [7:0]     sfr_addr_i,   // register offset
  input  wire logic           sfr_wr_i,     // write strobe, one cycle
  input  wire logic           sfr_rd_i,     // read strobe, one cycle
  input  wire tws_pkg::tws_byte_t sfr_wdata_i, // write data
  output tws_pkg::tws_byte_t  sfr_rdata_o,  // read data, valid after rd strobe
  input  wire logic           spi_mode_i,   // port in the other serial mode
  input  wire logic           scl_i,        // clock line level
  output logic                scl_o,        // clock line drive value
  output logic                scl_oe_o,     // clock line drive enable
  input  wire logic           sda_i,        // data line level
  output logic                sda_o,        // data line drive value
  output logic                sda_oe_o,     // data line drive enable
  output logic                pullup_en_o,  // weak pull-ups on both lines
  output logic                serial_irq_o, // byte flag gated by enable
  output logic                serial_pri_o  // interrupt priority bit
);
  import tws_pkg::*;

  // address match shared by sequencer and checks
  function automatic logic tws_hit(input tws_byte_t b, input tws_byte_t own);
    tws_hit = (b[7:1] == own[6:0]) && (b[7:1] != `TWS_GENCALL);
  endfunction

  logic       scl_s, sda_s, scl_q, sda_q;
  logic       dout_ff, ddrv_ff, cout_ff, din_ff, msel_ff, srst_ff, dir_ff, done_ff;
  tws_byte_t  data_ff, own_ff, iep_ff, ip_ff, shreg_ff;
  tws_state_e state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  tws_byte_t  nxt_shreg;
  logic       stretch_ff, set_done, ld_dir, ld_data;

  tws_sync u_sync_scl (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (scl_i),
    .q_o   (scl_s)
  );

  tws_sync u_sync_sda (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (sda_i),
    .q_o   (sda_s)
  );

  // previous synchronised levels for edge and condition detection
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // bus events; start/stop need the clock high on both samples
  wire scl_rise  = scl_s & ~scl_q;
  wire scl_fall  = ~scl_s & scl_q;
  wire start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  wire slave_run = ~msel_ff & ~srst_ff;
  wire full      = (cnt_ff == `TWS_FULL);
  wire hit       = tws_hit(shreg_ff, own_ff);
  wire [3:0] tx_idx = `TWS_LAST - cnt_ff;
  wire tx_bit    = data_ff[tx_idx[2:0]];

  // register decode
  wire wr_ctrl    = sfr_wr_i & (sfr_addr_i == `TWS_ADR_CTRL);
  wire wr_data    = sfr_wr_i & (sfr_addr_i == `TWS_ADR_DATA);
  wire wr_own     = sfr_wr_i & (sfr_addr_i == `TWS_ADR_OWN);
  wire wr_iep     = sfr_wr_i & (sfr_addr_i == `TWS_ADR_IEP);
  wire wr_ip      = sfr_wr_i & (sfr_addr_i == `TWS_ADR_IP);
  wire data_touch = (sfr_wr_i | sfr_rd_i) & (sfr_addr_i == `TWS_ADR_DATA);
  // flag clears once per access; a second clear is firmware's concern
  wire clr_done   = data_touch | (wr_ctrl & ~sfr_wdata_i[`TWS_B_DONE]);
  wire nxt_done   = set_done | (done_ff & ~clr_done);
  wire [7:0] ctrl_view = {dout_ff, ddrv_ff, cout_ff, din_ff, msel_ff, srst_ff, dir_ff, done_ff};

  // read mux; unmapped offsets read zero
  wire tws_byte_t rd_mux =
    (sfr_addr_i == `TWS_ADR_CTRL) ? ctrl_view :
    (sfr_addr_i == `TWS_ADR_DATA) ? data_ff   :
    (sfr_addr_i == `TWS_ADR_OWN)  ? own_ff    :
    (sfr_addr_i == `TWS_ADR_IEP)  ? iep_ff    :
    (sfr_addr_i == `TWS_ADR_IP)   ? ip_ff     : `TWS_RST_BYTE;

  // slave sequencer; only seven-bit addresses, no start-byte or ten-bit decoding
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_shreg = shreg_ff;
    set_done  = 1'b0;
    ld_dir    = 1'b0;
    ld_data   = 1'b0;
    case (state_ff)
      TWS_ADDR: begin
        if (scl_rise) begin
          nxt_shreg = {shreg_ff[6:0], sda_s};
          nxt_cnt   = cnt_ff + `TWS_CNT1;
        end else if (scl_fall && full) begin
          nxt_cnt = `TWS_CNT0;
          if (hit) begin
            set_done  = 1'b1;
            ld_dir    = 1'b1;
            ld_data   = 1'b1;
            nxt_state = TWS_ACKA;
          end else begin
            nxt_state = TWS_IDLE;
          end
        end
      end
      TWS_ACKA: begin
        if (scl_fall) begin
          nxt_state = dir_ff ? TWS_TX : TWS_RX;
          nxt_cnt   = `TWS_CNT0;
        end
      end
      TWS_RX: begin
        if (scl_rise) begin
          nxt_shreg = {shreg_ff[6:0], sda_s};
          nxt_cnt   = cnt_ff + `TWS_CNT1;
        end else if (scl_fall && full) begin
          ld_data   = 1'b1;
          set_done  = 1'b1;
          nxt_cnt   = `TWS_CNT0;
          nxt_state = TWS_ACKR;
        end
      end
      TWS_ACKR: begin
        if (scl_fall) begin
          nxt_state = TWS_RX;
        end
      end
      TWS_TX: begin
        if (scl_fall) begin
          nxt_cnt = cnt_ff + `TWS_CNT1;
          if (cnt_ff == `TWS_LAST) begin
            nxt_cnt   = `TWS_CNT0;
            nxt_state = TWS_ACKT;
          end
        end
      end
      TWS_ACKT: begin
        if (scl_rise) begin
          if (sda_s) begin
            nxt_state = TWS_IDLE;
          end else begin
            set_done = 1'b1;
          end
        end else if (scl_fall) begin
          nxt_state = TWS_TX;
        end
      end
      default: begin
        nxt_state = state_ff;
      end
    endcase
    // stop and reset take precedence over a start, which beats normal flow
    if (!slave_run) begin
      nxt_state = TWS_IDLE;
      set_done  = 1'b0;
      ld_dir    = 1'b0;
      ld_data   = 1'b0;
    end else if (stop_det) begin
      nxt_state = TWS_IDLE;
    end else if (start_det) begin
      nxt_state = TWS_ADDR;
      nxt_cnt   = `TWS_CNT0;
    end
  end

  // stretch starts at a falling clock so we never pull a high line low
  wire nxt_stretch = slave_run & nxt_done & (scl_fall | stretch_ff)
                     & (nxt_state != TWS_IDLE);
  wire slave_sda_low = (state_ff == TWS_ACKA) | (state_ff == TWS_ACKR)
                       | ((state_ff == TWS_TX) & ~tx_bit);

  // pin drive values; master clock driver always on, data line push-pull
  // a soft reset or mode change drops a stretch at once, not one cycle later
  wire nxt_scl_oe  = msel_ff | (stretch_ff & slave_run);
  wire nxt_scl_o   = msel_ff & cout_ff;
  wire nxt_sda_oe  = msel_ff ? ddrv_ff : (slave_run & slave_sda_low);
  wire nxt_sda_o   = msel_ff & dout_ff;

  // sequencer registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff   <= TWS_IDLE;
      cnt_ff     <= `TWS_CNT0;
      shreg_ff   <= `TWS_RST_BYTE;
      stretch_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      shreg_ff   <= nxt_shreg;
      stretch_ff <= nxt_stretch;
    end
  end

  // control register; direction and data-in are hardware-owned
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {dout_ff, ddrv_ff, cout_ff, msel_ff, srst_ff} <= 5'h00;
      din_ff  <= 1'b0;
      dir_ff  <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        dout_ff <= sfr_wdata_i[`TWS_B_DOUT];
        ddrv_ff <= sfr_wdata_i[`TWS_B_DDRV];
        cout_ff <= sfr_wdata_i[`TWS_B_COUT];
        msel_ff <= sfr_wdata_i[`TWS_B_MSEL];
        srst_ff <= sfr_wdata_i[`TWS_B_SRST];
      end
      // data in latches only on a rising clock with the driver off
      if (msel_ff && scl_rise && !ddrv_ff) begin
        din_ff <= sda_s;
      end
      if (ld_dir) begin
        dir_ff <= shreg_ff[0];
      end
      done_ff <= nxt_done;
    end
  end

  // data, own address and interrupt registers; received byte beats a firmware write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_ff <= `TWS_RST_BYTE;
      own_ff  <= `TWS_RST_BYTE;
      iep_ff  <= `TWS_RST_BYTE;
      ip_ff   <= `TWS_RST_BYTE;
    end else begin
      if (ld_data) begin
        data_ff <= shreg_ff;
      end else if (wr_data) begin
        data_ff <= sfr_wdata_i;
      end
      if (wr_own) begin
        own_ff <= sfr_wdata_i;
      end
      if (wr_iep) begin
        iep_ff <= sfr_wdata_i;
      end
      if (wr_ip) begin
        ip_ff <= sfr_wdata_i;
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sfr_rdata_o  <= `TWS_RST_BYTE;
      scl_o        <= 1'b0;
      scl_oe_o     <= 1'b0;
      sda_o        <= 1'b0;
      sda_oe_o     <= 1'b0;
      pullup_en_o  <= 1'b0;
      serial_irq_o <= 1'b0;
      serial_pri_o <= 1'b0;
    end else begin
      if (sfr_rd_i) begin
        sfr_rdata_o <= rd_mux;
      end
      scl_o        <= nxt_scl_o;
      scl_oe_o     <= nxt_scl_oe;
      sda_o        <= nxt_sda_o;
      sda_oe_o     <= nxt_sda_oe;
      pullup_en_o  <= ~spi_mode_i;
      serial_irq_o <= done_ff & iep_ff[`TWS_B_IEN];
      serial_pri_o <= iep_ff[`TWS_B_IPRI];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_addr_done;
    (state_ff == TWS_ADDR) && scl_fall && full && hit && slave_run && !stop_det && !start_det;
  endsequence

  sequence s_tx_nack;
    (state_ff == TWS_ACKT) && scl_rise && sda_s && slave_run;
  endsequence

  a_stop_idle: assert property (stop_det |=> state_ff == TWS_IDLE)
    else $error("stop did not return slave to idle");
  a_nack_idle: assert property (s_tx_nack |=> state_ff == TWS_IDLE && !$rose(done_ff))
    else $error("nack did not return slave to idle quietly");
  a_srst_idle: assert property (srst_ff && !msel_ff
      |=> state_ff == TWS_IDLE && !scl_oe_o ##1 !scl_oe_o)
    else $error("soft reset did not hold slave idle");
  a_gencall_quiet: assert property ((state_ff == TWS_ADDR) && scl_fall && full
      && (shreg_ff[7:1] == `TWS_GENCALL) |=> state_ff != TWS_ACKA && !$rose(done_ff))
    else $error("general call was acknowledged");
  a_restart_addr: assert property (start_det && slave_run && !stop_det
      |=> state_ff == TWS_ADDR && cnt_ff == `TWS_CNT0)
    else $error("start did not restart address reception");
  a_dir_load: assert property (s_addr_done |=> dir_ff == $past(shreg_ff[0]))
    else $error("direction bit not loaded from address byte");
  a_addr_flag: assert property (s_addr_done |=> done_ff && state_ff == TWS_ACKA ##1 sda_oe_o)
    else $error("address match did not flag and acknowledge");
  a_stretch_hold: assert property (stretch_ff && slave_run |=> scl_oe_o && !scl_o)
    else $error("clock not held low while stretching");
  a_stretch_free: assert property ($fell(done_ff) && !msel_ff |=> !scl_oe_o)
    else $error("clock not released after flag clear");
  a_flag_autoclr: assert property (done_ff && data_touch && !set_done |=> !done_ff)
    else $error("data register access did not clear flag");
  a_pullup_mode: assert property (1'b1 |=> pullup_en_o == !$past(spi_mode_i))
    else $error("pull-up enable does not follow serial mode");
  a_master_quiet: assert property (msel_ff |=> !$rose(done_ff) && scl_oe_o
      && scl_o == $past(cout_ff))
    else $error("master mode raised a byte event or lost clock drive");

endmodule

`default_nettype wire

//--- sim/tws_bus_model.sv
// tws_bus_model: external two-wire master that bit-bangs both lines for the bench.
// assumes the bench resolves each line as a wired-AND with an external pull-up.
`timescale 1ns/1ps
`default_nettype none

module tws_bus_model (
  input  wire logic clk_i,      // core clock, paces the link
  input  wire logic scl_i,      // resolved clock line
  input  wire logic sda_i,      // resolved data line
  output logic      scl_low_o,  // pull clock line low
  output logic      sda_low_o   // pull data line low
);
  // one link period is 8 core cycles (160 ns): 6 low, 2 high; the long low
  // phase lets the slave start its stretch before the master lets go
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // release the clock, wait out any stretch (bounded), sample, pull low
  task automatic pulse(output logic b);
    int w;
    w = 0;
    scl_low_o <= 1'b0;
    do begin
      tk(1);
      w++;
    end while (scl_i !== 1'b1 && w < 4000);
    tk(1);
    b = sda_i;
    scl_low_o <= 1'b1;
  endtask

  // data only changes while the clock is low
  task automatic bitx(input logic b, output logic r);
    tk(1);
    sda_low_o <= ~b;
    tk(5);
    pulse(r);
  endtask

  // eight bits msb first, then the acknowledge slot; d of FFh reads
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q,
                       output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(a, ack);
  endtask

  // works from idle and, as a repeated start, after a byte
  task automatic start;
    tk(1);
    sda_low_o <= 1'b0;
    tk(3);
    scl_low_o <= 1'b0;
    tk(3);
    sda_low_o <= 1'b1;
    tk(3);
    scl_low_o <= 1'b1;
  endtask

  task automatic stop;
    tk(1);
    sda_low_o <= 1'b1;
    tk(3);
    scl_low_o <= 1'b0;
    tk(3);
    sda_low_o <= 1'b0;
    tk(3);
  endtask

  // clock low with data high: no start or stop is made
  task automatic lo;
    tk(1);
    scl_low_o <= 1'b1;
  endtask

  task automatic hold(input logic b);
    sda_low_o <= ~b;
  endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
// testbench: drives the register port as firmware and the bus through a master model.
// assumes the pad resolves each line from all enables, with an external pull-up.
`timescale 1ns/1ps
`default_nettype none
`include "tws_cfg.svh"

module testbench;
  import tws_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic       sfr_wr_i = 1'b0;
  logic       sfr_rd_i = 1'b0;
  tws_byte_t  sfr_wdata_i = 8'h00;
  tws_byte_t  sfr_rdata_o;
  logic       spi_mode_i = 1'b0;
  logic       scl_o, scl_oe_o, sda_o, sda_oe_o, pullup_en_o, serial_irq_o, serial_pri_o;
  logic       m_scl_low, m_sda_low, ack;
  wire logic  scl_i, sda_i;
  logic [7:0] q, d;
  logic [15:0] bad [4] = '{16'h448A, 16'h0000, 16'h4401, 16'h44F0};
  logic [7:0] regs [6] = '{`TWS_ADR_CTRL, `TWS_ADR_DATA, `TWS_ADR_OWN, `TWS_ADR_IEP,
                           `TWS_ADR_IP, 8'h55};
  int         failures = 0;
  int         compares = 0;
  int         cyc = 0;

  // wired-AND of every driver; a released line floats up
  assign scl_i = ~m_scl_low & (scl_oe_o ? scl_o : 1'b1);
  assign sda_i = ~m_sda_low & (sda_oe_o ? sda_o : 1'b1);

  tws_top uut (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .spi_mode_i(spi_mode_i), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .pullup_en_o(pullup_en_o),
    .serial_irq_o(serial_irq_o), .serial_pri_o(serial_pri_o));
  tws_bus_model m (.clk_i(clk_i), .scl_i(scl_i), .sda_i(sda_i), .scl_low_o(m_scl_low),
    .sda_low_o(m_sda_low));

  always #10 clk_i = ~clk_i;

  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // a hang in a stretch or a wait ends the run here
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      $display("MISMATCH %0t run did not finish", $time);
      test_done();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr_i  <= a;
    sfr_wdata_i <= v;
    sfr_wr_i    <= 1'b1;
    tk(1);
    sfr_wr_i    <= 1'b0;
    tk(1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    sfr_addr_i <= a;
    sfr_rd_i   <= 1'b1;
    tk(1);
    sfr_rd_i   <= 1'b0;
    tk(2);
    v = sfr_rdata_o;
  endtask

  task automatic wait_irq;
    int w;
    w = 0;
    while (serial_irq_o !== 1'b1 && w < 3000) begin
      tk(1);
      w++;
    end
    chk({7'h00, serial_irq_o}, 8'h01, "byte flag");
  endtask

  // one byte event as firmware sees it; the flag is cleared by one data access only
  task automatic fw(input logic dir, input logic [7:0] v);
    wait_irq();
    tk(4);
    chk({6'h00, scl_oe_o, scl_o}, 8'h02, "clock stretched");
    rd(`TWS_ADR_CTRL, d);
    chk({7'h00, d[`TWS_B_DIR]}, {7'h00, dir}, "direction");
    if (dir) begin
      wr(`TWS_ADR_DATA, v);
    end else begin
      rd(`TWS_ADR_DATA, d);
      chk(d, v, "received byte");
    end
    tk(3);
    chk({7'h00, serial_irq_o}, 8'h00, "flag cleared");
  endtask

  initial begin
    tk(10);
    rst_i <= 1'b0;
    tk(1);
    foreach (regs[i]) begin
      rd(regs[i], d);
      chk(d, `TWS_RST_CTRL, "reset value");
    end
    wr(8'h55, 8'hFF);
    rd(8'h55, d);
    chk(d, 8'h00, "unmapped offset");
    wr(`TWS_ADR_IEP, 8'h11);
    rd(`TWS_ADR_IEP, d);
    chk({d[7:1], serial_pri_o}, 8'h11, "enable and priority");
    wr(`TWS_ADR_IP, 8'h5A);
    rd(`TWS_ADR_IP, d);
    chk(d, 8'h5A, "priority store");
    chk({7'h00, pullup_en_o}, 8'h01, "pull-ups on");
    spi_mode_i <= 1'b1;
    tk(3);
    chk({7'h00, pullup_en_o}, 8'h00, "pull-ups off");
    spi_mode_i <= 1'b0;
    $display("registers done");

    // master writes to the slave, stops, then clocks a byte with no start
    wr(`TWS_ADR_OWN, 8'h44);
    fork
      begin
        m.start();
        m.xbyte(8'h88, 1'b1, q, ack);
        chk({7'h00, ack}, 8'h00, "address ack");
        m.xbyte(8'h5A, 1'b1, q, ack);
        chk({7'h00, ack}, 8'h00, "data ack");
        m.stop();
        m.lo();
        m.xbyte(8'h88, 1'b1, q, ack);
        chk({7'h00, ack}, 8'h01, "idle after stop");
        m.stop();
      end
      begin
        fw(1'b0, 8'h88);
        fw(1'b0, 8'h5A);
      end
    join
    $display("slave receive done");

    foreach (bad[i]) begin
      wr(`TWS_ADR_OWN, bad[i][15:8]);
      m.start();
      m.xbyte(bad[i][7:0], 1'b1, q, ack);
      m.stop();
      chk({7'h00, ack}, 8'h01, "no ack");
      chk({7'h00, serial_irq_o}, 8'h00, "no flag");
    end
    $display("address refusal done");

    wr(`TWS_ADR_OWN, 8'h44);
    fork
      begin
        m.start();
        m.xbyte(8'h88, 1'b1, q, ack);
        m.start();
        m.xbyte(8'h89, 1'b1, q, ack);
        chk({7'h00, ack}, 8'h00, "read address ack");
        m.xbyte(8'hFF, 1'b1, q, ack);
        chk(q, 8'hC3, "slave sent byte");
        m.stop();
      end
      begin
        fw(1'b0, 8'h88);
        fw(1'b1, 8'hC3);
      end
    join
    tk(20);
    chk({6'h00, serial_irq_o, sda_oe_o}, 8'h00, "idle after nack");
    $display("repeated start read done");

    fork
      begin
        m.start();
        m.xbyte(8'h88, 1'b1, q, ack);
        m.xbyte(8'h5A, 1'b1, q, ack);
        chk({7'h00, ack}, 8'h01, "ignored after soft reset");
        m.stop();
      end
      begin
        wait_irq();
        wr(`TWS_ADR_CTRL, 8'h04);
        tk(3);
        chk({6'h00, scl_oe_o, sda_oe_o}, 8'h00, "lines released");
      end
    join
    chk({7'h00, serial_irq_o}, 8'h00, "no event in reset");
    wr(`TWS_ADR_CTRL, 8'h00);
    $display("soft reset done");

    wr(`TWS_ADR_CTRL, 8'hA8);
    tk(2);
    chk({5'h00, scl_oe_o, scl_o, sda_oe_o}, 8'h06, "master idle drive");
    for (int b = 0; b < 2; b++) begin
      m.hold(b[0]);
      wr(`TWS_ADR_CTRL, 8'h88);
      wr(`TWS_ADR_CTRL, 8'hA8);
      tk(4);
      rd(`TWS_ADR_CTRL, d);
      chk(d, {3'b101, b[0], 4'h8}, "data in on clock rise");
    end
    m.hold(1'b0);
    wr(`TWS_ADR_CTRL, 8'hC8);
    wr(`TWS_ADR_CTRL, 8'hE8);
    tk(4);
    rd(`TWS_ADR_CTRL, d);
    chk(d, 8'hF8, "no sampling while driving");
    chk({6'h00, sda_oe_o, sda_o}, 8'h03, "data driven");
    chk({7'h00, serial_irq_o}, 8'h00, "no byte events");
    m.hold(1'b1);
    wr(`TWS_ADR_CTRL, 8'h00);
    $display("master mode done");
    test_done();
  end
endmodule
`default_nettype wire
